// ===== pkg/drive_status_pkg.sv
// Constants, register map and encodings for the drive status output block
package drive_status_pkg;
  localparam int          CLK_HZ          = 25_000_000;
  // Frequencies in 0.01 Hz steps
  localparam logic [15:0] START_FREQ_RST  = 16'h0032;
  localparam logic [15:0] DETECT_FREQ_RST = 16'h1770;
  localparam logic [15:0] FREQ_FS_RST     = 16'h1770;
  localparam logic [15:0] CUR_FS_RST      = 16'h03E8;
  localparam logic [6:0]  BAND_PCT_RST    = 7'h0A;
  localparam logic [6:0]  BAND_PCT_MAX    = 7'h64;
  localparam logic [6:0]  PCT_FULL        = 7'h64;
  localparam logic [3:0]  CTRL_RST        = 4'h0;
  // Meter: 1440 pulse/s at the reference, toggle output, step/unit = 2*1440/CLK_HZ
  localparam int          METER_PPS       = 1440;
  localparam logic [15:0] METER_REF_GP    = 16'h1770;
  localparam logic [15:0] METER_REF_PM_S  = 16'h2328;
  localparam logic [15:0] METER_REF_PM_L  = 16'h2EE0;
  localparam logic [4:0]  METER_STEP      = 5'(2 * METER_PPS * (CLK_HZ / 320) / CLK_HZ);
  localparam logic [16:0] METER_UNIT      = 17'(CLK_HZ / 320);
  // Analog monitor code range
  localparam logic [9:0]  AM_CODE_MAX     = 10'h3FF;
  localparam logic [3:0]  AM_STEPS        = 4'hA;
  // Serial baud divisors, clamped into the allowed baud range
  localparam int          BAUD_MAX        = 38400;
  localparam int          BAUD_PANEL_MIN  = 4800;
  localparam int          BAUD_TERM_MIN   = 300;
  localparam int          BAUD_RST        = 9600;
  localparam logic [16:0] DIV_MIN         = 17'((CLK_HZ + BAUD_MAX - 1) / BAUD_MAX);
  localparam logic [16:0] DIV_PANEL_MAX   = 17'(CLK_HZ / BAUD_PANEL_MIN);
  localparam logic [16:0] DIV_TERM_MAX    = 17'(CLK_HZ / BAUD_TERM_MIN);
  localparam logic [16:0] DIV_RST         = 17'(CLK_HZ / BAUD_RST);
  localparam logic [3:0]  UART_LAST_BIT   = 4'h9;
  // Register byte offsets
  localparam logic [7:0]  A_CTRL          = 8'h00;
  localparam logic [7:0]  A_BAND          = 8'h04;
  localparam logic [7:0]  A_DETECT        = 8'h08;
  localparam logic [7:0]  A_START         = 8'h0C;
  localparam logic [7:0]  A_FREQ_FS       = 8'h10;
  localparam logic [7:0]  A_CUR_FS        = 8'h14;
  localparam logic [7:0]  A_FLAGS         = 8'h18;
  localparam logic [7:0]  A_IRQ_STAT      = 8'h1C;
  localparam logic [7:0]  A_IRQ_MASK      = 8'h20;
  localparam logic [7:0]  A_PANEL_DIV     = 8'h24;
  localparam logic [7:0]  A_TERM_DIV      = 8'h28;
  localparam logic [7:0]  A_PANEL_DATA    = 8'h2C;
  localparam logic [7:0]  A_TERM_DATA     = 8'h30;
  localparam logic [7:0]  A_SER_STAT      = 8'h34;
  // CTRL bits
  localparam int          CTRL_PM         = 0;
  localparam int          CTRL_LARGE      = 1;
  localparam int          CTRL_METER_CUR  = 2;
  localparam int          CTRL_AM_CUR     = 3;
  localparam int          NUM_EVT         = 7;
  typedef enum logic {AM_IDLE = 1'b0, AM_RUN = 1'b1} am_state_e;
endpackage : drive_status_pkg

// ===== core/drive_status_outputs.sv
// Drive status flags, meter pulse, analog monitor and two RS-485 ports
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module drive_status_outputs import drive_status_pkg::*; #(
  parameter int FW = 16
) (
  // Clock and reset
  input  wire logic          CLK,
  input  wire logic          SRST,
  // Register port
  input  wire logic [7:0]    ADDR,
  input  wire logic [31:0]   WDATA,
  input  wire logic          WR,
  input  wire logic          RD,
  output logic      [31:0]   RDATA,
  // Drive state
  input  wire logic [FW-1:0] OUT_FREQ,
  input  wire logic [FW-1:0] SET_FREQ,
  input  wire logic [FW-1:0] OUT_CURRENT,
  input  wire logic          ACCEL,
  input  wire logic          DECEL,
  input  wire logic          DC_BRAKE,
  input  wire logic          STALL_ACTIVE,
  input  wire logic          INST_PF_ACTIVE,
  input  wire logic          UNDERVOLT_ACTIVE,
  input  wire logic          INV_RESET,
  // Open-collector flags, low = transistor on
  output logic               MOTOR_ACTIVE_OUT_N,
  output logic               AT_SPEED_OUT_N,
  output logic               STALL_WARNING_OUT_N,
  output logic               POWER_DIP_OUT_N,
  output logic               FREQ_THRESHOLD_OUT_N,
  // Monitors
  output logic               METER_PULSE_OUT,
  output logic      [9:0]    ANALOG_MONITOR_OUT,
  // Panel port, one half-duplex pair
  input  wire logic          PANEL_SERIAL_PORT_I,
  output logic               PANEL_SERIAL_PORT_O,
  output logic               PANEL_SERIAL_PORT_OE_N,
  // Terminal port, separate pairs
  input  wire logic          TERM_RXD_IN,
  output logic               TERM_TXD_OUT,
  output logic               TERM_TX_OE_N,
  // Interrupt
  output logic               IRQ
);
  // Configuration registers
  logic [3:0]    ctrl_q, ctrl_d;
  logic [6:0]    band_q, band_d;
  logic [FW-1:0] detect_q, detect_d, start_q, start_d, freq_fs_q, freq_fs_d;
  logic [FW-1:0] current_fullscale_setting_q, current_fullscale_setting_d;
  logic [16:0]   div_q [2];
  logic [16:0]   div_d [2];
  logic [NUM_EVT-1:0] stat_q, stat_d, mask_q, mask_d, evt;
  logic [31:0]   rdata_d;
  logic          irq_d;
  // Serial port wiring
  logic [1:0]    rxd, tx_go, tx_busy, rx_valid, rx_err;
  logic [7:0]    rx_data [2];
  logic          analog_monitor_item_setting;
  assign analog_monitor_item_setting = ctrl_q[CTRL_AM_CUR];

  // Flags
  logic [4:0]    flags_q, flags_d;
  logic          stopped, in_band;
  logic [FW+7:0] out_x100, lo_lim, hi_lim;
  always_comb begin
    stopped  = OUT_FREQ < start_q;
    out_x100 = OUT_FREQ * PCT_FULL;
    lo_lim   = SET_FREQ * (PCT_FULL - band_q);
    hi_lim   = SET_FREQ * (PCT_FULL + band_q);
    in_band  = (out_x100 >= lo_lim) && (out_x100 <= hi_lim);
    flags_d[0] = !((OUT_FREQ >= start_q) && !DC_BRAKE);
    flags_d[1] = !(in_band && !stopped && !ACCEL && !DECEL);
    flags_d[2] = !STALL_ACTIVE;
    flags_d[3] = !(INST_PF_ACTIVE || UNDERVOLT_ACTIVE);
    flags_d[4] = !(OUT_FREQ >= detect_q);
    if (INV_RESET) begin
      flags_d = '1;
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      flags_q <= '1;
    end else begin
      flags_q <= flags_d;
    end
  end
  // Low drives the collector transistor on
  assign MOTOR_ACTIVE_OUT_N   = flags_q[0];
  assign AT_SPEED_OUT_N       = flags_q[1];
  assign STALL_WARNING_OUT_N  = flags_q[2];
  assign POWER_DIP_OUT_N      = flags_q[3];
  assign FREQ_THRESHOLD_OUT_N = flags_q[4];

  // Meter pulse: phase accumulator, output toggles at each wrap
  logic [39:0]   macc_q, macc_d, msum, mth;
  logic          mout_q, mout_d;
  logic [FW-1:0] mval, mref;
  always_comb begin
    mval = ctrl_q[CTRL_METER_CUR] ? OUT_CURRENT : OUT_FREQ;
    if (ctrl_q[CTRL_METER_CUR]) begin
      mref = current_fullscale_setting_q;
    end else if (ctrl_q[CTRL_PM]) begin
      mref = ctrl_q[CTRL_LARGE] ? METER_REF_PM_L : METER_REF_PM_S;
    end else begin
      mref = METER_REF_GP;
    end
    mth    = 40'(mref * METER_UNIT);
    msum   = macc_q + 40'(mval * METER_STEP);
    macc_d = msum;
    mout_d = mout_q;
    if (msum >= mth) begin
      macc_d = msum - mth;
      mout_d = !mout_q;
    end
    if (INV_RESET) begin
      macc_d = '0;
      mout_d = 1'b0;
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      macc_q <= '0;
      mout_q <= 1'b0;
    end else begin
      macc_q <= macc_d;
      mout_q <= mout_d;
    end
  end
  assign METER_PULSE_OUT = mout_q;

  // Analog monitor: code = value * 1024 / full scale, clamped, bit-serial divide
  am_state_e     am_q, am_d;
  logic [FW:0]   rem_q, rem_d, rem2;
  logic [FW-1:0] fs_q, fs_d;
  logic [9:0]    quo_q, quo_d, am_out_q, am_out_d;
  logic [3:0]    step_q, step_d;
  always_comb begin
    am_d = am_q;
    rem_d = rem_q;
    fs_d = fs_q;
    quo_d = quo_q;
    step_d = step_q;
    am_out_d = am_out_q;
    rem2 = {rem_q[FW-1:0], 1'b0};
    case (am_q)
      AM_IDLE: begin
        fs_d  = analog_monitor_item_setting ? current_fullscale_setting_q : freq_fs_q;
        rem_d = {1'b0, analog_monitor_item_setting ? OUT_CURRENT : OUT_FREQ};
        if (rem_d >= {1'b0, fs_d}) begin
          am_out_d = AM_CODE_MAX;
        end else begin
          quo_d  = '0;
          step_d = AM_STEPS;
          am_d   = AM_RUN;
        end
      end
      AM_RUN: begin
        if (rem2 >= {1'b0, fs_q}) begin
          rem_d = rem2 - {1'b0, fs_q};
          quo_d = {quo_q[8:0], 1'b1};
        end else begin
          rem_d = rem2;
          quo_d = {quo_q[8:0], 1'b0};
        end
        step_d = step_q - 4'h1;
        if (step_q == 4'h1) begin
          am_out_d = quo_d;
          am_d = AM_IDLE;
        end
      end
      default: am_d = AM_IDLE;
    endcase
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      am_q <= AM_IDLE;
      rem_q <= '0;
      fs_q <= '0;
      quo_q <= '0;
      step_q <= '0;
      am_out_q <= '0;
    end else begin
      am_q <= am_d;
      rem_q <= rem_d;
      fs_q <= fs_d;
      quo_q <= quo_d;
      step_q <= step_d;
      am_out_q <= am_out_d;
    end
  end
  assign ANALOG_MONITOR_OUT = am_out_q;

  // Serial ports: 8N1 shifters, port 0 panel, port 1 terminal
  logic [1:0] txd, tx_oe_n;
  assign rxd   = {TERM_RXD_IN, PANEL_SERIAL_PORT_I};
  assign tx_go = {WR && ADDR == A_TERM_DATA, WR && ADDR == A_PANEL_DATA};
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_uart
      logic [16:0] tcnt_q, tcnt_d, rcnt_q, rcnt_d;
      logic [3:0]  tbit_q, tbit_d, rbit_q, rbit_d;
      logic [9:0]  tsh_q, tsh_d;
      logic [7:0]  rsh_q, rsh_d, rdat_q, rdat_d;
      logic        tbusy_q, tbusy_d, rbusy_q, rbusy_d, oe_n_q, rv_q, rv_d, re_q, re_d;
      always_comb begin
        tcnt_d = tcnt_q;
        tbit_d = tbit_q;
        tsh_d = tsh_q;
        tbusy_d = tbusy_q;
        rcnt_d = rcnt_q;
        rbit_d = rbit_q;
        rsh_d = rsh_q;
        rdat_d = rdat_q;
        rbusy_d = rbusy_q;
        rv_d = 1'b0;
        re_d = 1'b0;
        if (tbusy_q) begin
          if (tcnt_q == '0) begin
            tcnt_d = div_q[p] - 17'h1;
            tsh_d = {1'b1, tsh_q[9:1]};
            tbit_d = tbit_q + 4'h1;
            tbusy_d = tbit_q != UART_LAST_BIT;
          end else begin
            tcnt_d = tcnt_q - 17'h1;
          end
        end else if (tx_go[p]) begin
          tsh_d = {1'b1, WDATA[7:0], 1'b0};
          tbit_d = '0;
          tcnt_d = div_q[p] - 17'h1;
          tbusy_d = 1'b1;
        end
        // Panel pair is shared, so its own echo is not received
        if (!rbusy_q) begin
          if (!rxd[p] && !(p == 0 && tbusy_q)) begin
            rbusy_d = 1'b1;
            rbit_d = '0;
            rcnt_d = {1'b0, div_q[p][16:1]};
          end
        end else if (rcnt_q != '0) begin
          rcnt_d = rcnt_q - 17'h1;
        end else begin
          rcnt_d = div_q[p] - 17'h1;
          rbit_d = rbit_q + 4'h1;
          if (rbit_q == '0) begin
            rbusy_d = !rxd[p];
          end else if (rbit_q == UART_LAST_BIT) begin
            rbusy_d = 1'b0;
            rv_d = rxd[p];
            re_d = !rxd[p];
            if (rxd[p]) begin
              rdat_d = rsh_q;
            end
          end else begin
            rsh_d = {rxd[p], rsh_q[7:1]};
          end
        end
      end
      always_ff @(posedge CLK) begin
        if (SRST) begin
          tcnt_q <= '0;
          tbit_q <= '0;
          tsh_q <= '1;
          tbusy_q <= 1'b0;
          oe_n_q <= 1'b1;
          rcnt_q <= '0;
          rbit_q <= '0;
          rsh_q <= '0;
          rdat_q <= '0;
          rbusy_q <= 1'b0;
          rv_q <= 1'b0;
          re_q <= 1'b0;
        end else begin
          tcnt_q <= tcnt_d;
          tbit_q <= tbit_d;
          tsh_q <= tsh_d;
          tbusy_q <= tbusy_d;
          oe_n_q <= !tbusy_d;
          rcnt_q <= rcnt_d;
          rbit_q <= rbit_d;
          rsh_q <= rsh_d;
          rdat_q <= rdat_d;
          rbusy_q <= rbusy_d;
          rv_q <= rv_d;
          re_q <= re_d;
        end
      end
      assign txd[p] = tsh_q[0];
      assign tx_oe_n[p] = oe_n_q;
      assign tx_busy[p] = tbusy_q;
      assign rx_valid[p] = rv_q;
      assign rx_err[p] = re_q;
      assign rx_data[p] = rdat_q;
    end
  endgenerate
  assign PANEL_SERIAL_PORT_O = txd[0];
  assign PANEL_SERIAL_PORT_OE_N = tx_oe_n[0];
  assign TERM_TXD_OUT = txd[1];
  assign TERM_TX_OE_N = tx_oe_n[1];

  // Register port and interrupt status
  function automatic logic [16:0] clamp_div(input logic [31:0] v, input logic [16:0] hi);
    if (v < 32'(DIV_MIN)) begin
      return DIV_MIN;
    end
    return (v > 32'(hi)) ? hi : v[16:0];
  endfunction : clamp_div
  function automatic logic [FW-1:0] nonzero(input logic [FW-1:0] v);
    return (v == '0) ? FW'(1) : v;
  endfunction : nonzero
  always_comb begin
    ctrl_d = ctrl_q;
    band_d = band_q;
    detect_d = detect_q;
    start_d = start_q;
    freq_fs_d = freq_fs_q;
    current_fullscale_setting_d = current_fullscale_setting_q;
    div_d = div_q;
    mask_d = mask_q;
    evt = {1'b0, |rx_err, rx_valid, flags_q[4] && !flags_d[4], flags_q[3] && !flags_d[3],
           flags_q[2] && !flags_d[2]};
    stat_d = stat_q;
    if (WR) begin
      case (ADDR)
        A_CTRL:      ctrl_d = WDATA[3:0];
        A_BAND:      band_d = (WDATA[6:0] > BAND_PCT_MAX || |WDATA[31:7]) ? BAND_PCT_MAX : WDATA[6:0];
        A_DETECT:    detect_d = WDATA[FW-1:0];
        A_START:     start_d = WDATA[FW-1:0];
        A_FREQ_FS:   freq_fs_d = nonzero(WDATA[FW-1:0]);
        A_CUR_FS:    current_fullscale_setting_d = nonzero(WDATA[FW-1:0]);
        A_IRQ_STAT:  stat_d = stat_q & ~WDATA[NUM_EVT-1:0];
        A_IRQ_MASK:  mask_d = WDATA[NUM_EVT-1:0];
        A_PANEL_DIV: div_d[0] = clamp_div(WDATA, DIV_PANEL_MAX);
        A_TERM_DIV:  div_d[1] = clamp_div(WDATA, DIV_TERM_MAX);
        default:     ;
      endcase
    end
    stat_d = stat_d | evt;
    irq_d = |(stat_d & mask_d);
    rdata_d = '0;
    if (RD) begin
      case (ADDR)
        A_CTRL:       rdata_d = 32'(ctrl_q);
        A_BAND:       rdata_d = 32'(band_q);
        A_DETECT:     rdata_d = 32'(detect_q);
        A_START:      rdata_d = 32'(start_q);
        A_FREQ_FS:    rdata_d = 32'(freq_fs_q);
        A_CUR_FS:     rdata_d = 32'(current_fullscale_setting_q);
        A_FLAGS:      rdata_d = 32'(flags_q);
        A_IRQ_STAT:   rdata_d = 32'(stat_q);
        A_IRQ_MASK:   rdata_d = 32'(mask_q);
        A_PANEL_DIV:  rdata_d = 32'(div_q[0]);
        A_TERM_DIV:   rdata_d = 32'(div_q[1]);
        A_PANEL_DATA: rdata_d = 32'(rx_data[0]);
        A_TERM_DATA:  rdata_d = 32'(rx_data[1]);
        A_SER_STAT:   rdata_d = 32'(tx_busy);
        default:      rdata_d = '0;
      endcase
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ctrl_q <= CTRL_RST;
      band_q <= BAND_PCT_RST;
      detect_q <= DETECT_FREQ_RST;
      start_q <= START_FREQ_RST;
      freq_fs_q <= FREQ_FS_RST;
      current_fullscale_setting_q <= CUR_FS_RST;
      div_q[0] <= DIV_RST;
      div_q[1] <= DIV_RST;
      stat_q <= '0;
      mask_q <= '0;
      RDATA <= '0;
      IRQ <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      band_q <= band_d;
      detect_q <= detect_d;
      start_q <= start_d;
      freq_fs_q <= freq_fs_d;
      current_fullscale_setting_q <= current_fullscale_setting_d;
      div_q <= div_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      RDATA <= rdata_d;
      IRQ <= irq_d;
    end
  end
endmodule : drive_status_outputs
`default_nettype wire

// ===== test/drive_status_monitor.sv
// Port checker for the drive status output block
`timescale 1ns/100ps
`default_nettype none
module drive_status_monitor import drive_status_pkg::*; #(
  parameter int FW = 16
) (
  // Clock, reset and drive state
  input wire logic          CLK,
  input wire logic          SRST,
  input wire logic [FW-1:0] OUT_FREQ,
  input wire logic          ACCEL,
  input wire logic          DECEL,
  input wire logic          DC_BRAKE,
  input wire logic          STALL_ACTIVE,
  input wire logic          INST_PF_ACTIVE,
  input wire logic          UNDERVOLT_ACTIVE,
  input wire logic          INV_RESET,
  // Outputs watched
  input wire logic          MOTOR_ACTIVE_OUT_N,
  input wire logic          AT_SPEED_OUT_N,
  input wire logic          STALL_WARNING_OUT_N,
  input wire logic          POWER_DIP_OUT_N,
  input wire logic          FREQ_THRESHOLD_OUT_N,
  input wire logic          METER_PULSE_OUT,
  input wire logic          PANEL_SERIAL_PORT_O,
  input wire logic          PANEL_SERIAL_PORT_OE_N
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  // Detect and start thresholds are never rewritten by the bench
  property p_stall_on; STALL_ACTIVE && !INV_RESET |=> !STALL_WARNING_OUT_N; endproperty
  a_stall_on: assert property (p_stall_on) else $error("stall flag not low");
  property p_stall_off; !STALL_ACTIVE |=> STALL_WARNING_OUT_N; endproperty
  a_stall_off: assert property (p_stall_off) else $error("stall flag not released");
  property p_dip; (INST_PF_ACTIVE || UNDERVOLT_ACTIVE) && !INV_RESET |=> !POWER_DIP_OUT_N; endproperty
  a_dip: assert property (p_dip) else $error("dip flag not low");
  property p_fthr; !INV_RESET |=> FREQ_THRESHOLD_OUT_N == ($past(OUT_FREQ) < DETECT_FREQ_RST); endproperty
  a_fthr: assert property (p_fthr) else $error("threshold flag wrong");
  property p_speed; ACCEL || DECEL || OUT_FREQ < START_FREQ_RST |=> AT_SPEED_OUT_N; endproperty
  a_speed: assert property (p_speed) else $error("at speed flag low while ramping or stopped");
  property p_motor; DC_BRAKE || OUT_FREQ < START_FREQ_RST |=> MOTOR_ACTIVE_OUT_N; endproperty
  a_motor: assert property (p_motor) else $error("motor flag low while stopped");
  property p_inv;
    INV_RESET |=> &{MOTOR_ACTIVE_OUT_N, AT_SPEED_OUT_N, STALL_WARNING_OUT_N, POWER_DIP_OUT_N, FREQ_THRESHOLD_OUT_N};
  endproperty
  a_inv: assert property (p_inv) else $error("flag low during inverter reset");
  property p_meter; INV_RESET [*3] |-> !METER_PULSE_OUT; endproperty
  a_meter: assert property (p_meter) else $error("meter active during inverter reset");
  property p_tx; $fell(PANEL_SERIAL_PORT_OE_N) |-> !PANEL_SERIAL_PORT_O [*8]; endproperty
  a_tx: assert property (p_tx) else $error("panel frame lacks start bit");
endmodule : drive_status_monitor
bind drive_status_outputs drive_status_monitor #(.FW(FW)) mon_i (
  .CLK(CLK), .SRST(SRST), .OUT_FREQ(OUT_FREQ), .ACCEL(ACCEL), .DECEL(DECEL), .DC_BRAKE(DC_BRAKE),
  .STALL_ACTIVE(STALL_ACTIVE), .INST_PF_ACTIVE(INST_PF_ACTIVE), .UNDERVOLT_ACTIVE(UNDERVOLT_ACTIVE),
  .INV_RESET(INV_RESET), .MOTOR_ACTIVE_OUT_N(MOTOR_ACTIVE_OUT_N), .AT_SPEED_OUT_N(AT_SPEED_OUT_N),
  .STALL_WARNING_OUT_N(STALL_WARNING_OUT_N), .POWER_DIP_OUT_N(POWER_DIP_OUT_N),
  .FREQ_THRESHOLD_OUT_N(FREQ_THRESHOLD_OUT_N), .METER_PULSE_OUT(METER_PULSE_OUT),
  .PANEL_SERIAL_PORT_O(PANEL_SERIAL_PORT_O), .PANEL_SERIAL_PORT_OE_N(PANEL_SERIAL_PORT_OE_N));
`default_nettype wire

// ===== test/serial_peer.sv
// Serial partner: one RS-485 station, 8N1, LSB first
`timescale 1ns/100ps
`default_nettype none
module serial_peer #(
  parameter int BIT = 652
) (
  // Clock and line pair
  input  wire logic CLK,
  input  wire logic rx_line,
  output var logic  tx_line
);
  logic [7:0] rx_q[$];
  logic [7:0] b;
  // 652 cycles is about 38.3 kbaud, inside both ports' range
  initial tx_line = 1'b1;
  // Receiver sampled mid bit; a bad stop bit loses the byte
  always begin
    @(negedge rx_line);
    repeat (BIT / 2) @(posedge CLK);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge CLK);
      b[i] = rx_line;
    end
    repeat (BIT) @(posedge CLK);
    if (rx_line) rx_q.push_back(b);
  end
  // One station at a time talks on the pair
  task send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge CLK);
      tx_line <= f[i];
      repeat (BIT - 1) @(posedge CLK);
    end
  endtask : send
endmodule : serial_peer
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the drive status output block
`timescale 1ns/100ps
`default_nettype none
module tb import drive_status_pkg::*;;
  logic        CLK, SRST, WR, RD, ACCEL, DECEL, DC_BRAKE, STALL_ACTIVE;
  logic        INST_PF_ACTIVE, UNDERVOLT_ACTIVE, INV_RESET;
  logic [7:0]  ADDR;
  logic [31:0] WDATA, RDATA, r;
  logic [15:0] OUT_FREQ, SET_FREQ, OUT_CURRENT;
  logic        MOTOR_ACTIVE_OUT_N, AT_SPEED_OUT_N, STALL_WARNING_OUT_N, POWER_DIP_OUT_N, FREQ_THRESHOLD_OUT_N;
  logic        METER_PULSE_OUT, PANEL_SERIAL_PORT_O, PANEL_SERIAL_PORT_OE_N, TERM_TXD_OUT, TERM_TX_OE_N, IRQ;
  logic [9:0]  ANALOG_MONITOR_OUT;
  wire logic   pan_tx, trm_tx;
  int          err_total, checked, band, seed, n, e;
  logic [7:0]  ra[8] = '{A_CTRL, A_BAND, A_DETECT, A_START, A_FREQ_FS, A_CUR_FS, A_IRQ_MASK, 8'h3C};
  logic [15:0] rv[8] = '{16'h0, 16'h000A, 16'h1770, 16'h0032, 16'h1770, 16'h03E8, 16'h0, 16'h0};
  int          mref[4] = '{6000, 9000, 12000, 1000};
  logic [3:0]  mctl[4] = '{4'h0, 4'h1, 4'h3, 4'h4};
  logic [7:0]  d1, d2;
  logic        ml;
  always #20 CLK = ~CLK;
  drive_status_outputs drive_status_outputs_i (.CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .OUT_FREQ(OUT_FREQ), .SET_FREQ(SET_FREQ), .OUT_CURRENT(OUT_CURRENT), .ACCEL(ACCEL),
    .DECEL(DECEL), .DC_BRAKE(DC_BRAKE), .STALL_ACTIVE(STALL_ACTIVE), .INST_PF_ACTIVE(INST_PF_ACTIVE),
    .UNDERVOLT_ACTIVE(UNDERVOLT_ACTIVE), .INV_RESET(INV_RESET), .MOTOR_ACTIVE_OUT_N(MOTOR_ACTIVE_OUT_N),
    .AT_SPEED_OUT_N(AT_SPEED_OUT_N), .STALL_WARNING_OUT_N(STALL_WARNING_OUT_N), .POWER_DIP_OUT_N(POWER_DIP_OUT_N),
    .FREQ_THRESHOLD_OUT_N(FREQ_THRESHOLD_OUT_N), .METER_PULSE_OUT(METER_PULSE_OUT),
    .ANALOG_MONITOR_OUT(ANALOG_MONITOR_OUT), .PANEL_SERIAL_PORT_I(PANEL_SERIAL_PORT_OE_N ? pan_tx : PANEL_SERIAL_PORT_O),
    .PANEL_SERIAL_PORT_O(PANEL_SERIAL_PORT_O), .PANEL_SERIAL_PORT_OE_N(PANEL_SERIAL_PORT_OE_N),
    .TERM_RXD_IN(trm_tx), .TERM_TXD_OUT(TERM_TXD_OUT), .TERM_TX_OE_N(TERM_TX_OE_N), .IRQ(IRQ));
  // Failsafe bias holds a released pair at mark
  serial_peer pan_peer (.CLK(CLK), .rx_line(PANEL_SERIAL_PORT_OE_N | PANEL_SERIAL_PORT_O), .tx_line(pan_tx));
  serial_peer trm_peer (.CLK(CLK), .rx_line(TERM_TX_OE_N | TERM_TXD_OUT), .tx_line(trm_tx));
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task test_done;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    @(negedge CLK);
    d = RDATA;
  endtask : rd
  // Bits: accel, decel, brake, stall, power fail, undervolt, inverter reset
  task apply(input int o, input logic [6:0] b);
    logic [4:0] x;
    @(posedge CLK);
    OUT_FREQ <= 16'(o);
    {ACCEL, DECEL, DC_BRAKE, STALL_ACTIVE, INST_PF_ACTIVE, UNDERVOLT_ACTIVE, INV_RESET} <= b;
    x = ~{o >= 50 && !b[4], o * 100 >= 6000 * (100 - band) && o * 100 <= 6000 * (100 + band) && o >= 50
          && !b[6] && !b[5], b[3], b[2] | b[1], o >= 6000};
    if (b[0]) x = 5'h1F;
    @(posedge CLK);
    @(negedge CLK);
    chk("flags", {MOTOR_ACTIVE_OUT_N, AT_SPEED_OUT_N, STALL_WARNING_OUT_N, POWER_DIP_OUT_N,
        FREQ_THRESHOLD_OUT_N}, x);
  endtask : apply
  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge CLK);
    chk("timeout", 0, 1);
    test_done;
  end
  initial begin
    seed = 32'hed8e;
    err_total = 0;
    checked = 0;
    band = 10;
    CLK = 1'b0;
    SRST = 1'b1;
    {WR, RD, ACCEL, DECEL, DC_BRAKE, STALL_ACTIVE, INST_PF_ACTIVE, UNDERVOLT_ACTIVE, INV_RESET} = '0;
    ADDR = 8'h00;
    WDATA = 32'h0;
    OUT_FREQ = 16'h0000;
    OUT_CURRENT = 16'h0000;
    SET_FREQ = 16'h1770;
    repeat (16) @(posedge CLK);
    SRST <= 1'b0;
    @(negedge CLK);
    chk("reset flags", {MOTOR_ACTIVE_OUT_N, AT_SPEED_OUT_N, STALL_WARNING_OUT_N, POWER_DIP_OUT_N,
        FREQ_THRESHOLD_OUT_N}, 5'h1F);
    chk("reset lines", {METER_PULSE_OUT, PANEL_SERIAL_PORT_O, PANEL_SERIAL_PORT_OE_N, TERM_TXD_OUT, TERM_TX_OE_N,
        IRQ}, 6'h1E);
    for (int i = 0; i < 8; i++) begin
      rd(ra[i], r);
      chk("reset reg", r, 32'(rv[i]));
    end
    apply(0, 7'h00);
    apply(30, 7'h00);
    apply(6000, 7'h10);
    apply(6000, 7'h01);
    apply(6000, 7'h00);
    for (int i = 0; i < 40; i++) begin
      if (i == 20) begin
        wr(A_BAND, 32'h5);
        band = 5;
      end
      apply(5000 + {$random(seed)} % 2000, 7'($random(seed)) & 7'h7E);
    end
    wr(A_BAND, 32'hC8);
    rd(A_BAND, r);
    chk("band clamp", r, 32'h64);
    band = 100;
    apply(6000, 7'h00);
    wr(A_IRQ_STAT, 32'h7F);
    wr(A_IRQ_MASK, 32'h1);
    @(negedge CLK);
    chk("irq idle", IRQ, 1'b0);
    apply(6000, 7'h08);
    chk("irq stall", IRQ, 1'b1);
    wr(A_IRQ_STAT, 32'h1);
    @(negedge CLK);
    chk("irq cleared", IRQ, 1'b0);
    // Second reset in mid-run restores the defaults
    @(posedge CLK);
    SRST <= 1'b1;
    repeat (2) @(posedge CLK);
    SRST <= 1'b0;
    rd(A_BAND, r);
    chk("band after reset", r, 32'hA);
    band = 10;
    // Meter: value four times the reference, 6000 cycles from a cleared accumulator
    for (int i = 0; i < 5; i++) begin
      wr(A_CTRL, 32'(mctl[i % 4]));
      @(posedge CLK);
      OUT_FREQ <= 16'(4 * mref[i % 4]);
      OUT_CURRENT <= 16'(4 * mref[i % 4]);
      INV_RESET <= 1'b1;
      @(posedge CLK);
      INV_RESET <= (i == 4);
      e = (i == 4) ? 0 : int'(longint'(6000) * 2 * METER_PPS * (4 * mref[i % 4]) / (longint'(mref[i % 4]) * CLK_HZ));
      n = 0;
      @(negedge CLK);
      ml = METER_PULSE_OUT;
      repeat (6000) begin
        @(negedge CLK);
        if (METER_PULSE_OUT !== ml) n++;
        ml = METER_PULSE_OUT;
      end
      chk("meter toggles", n, e);
    end
    @(posedge CLK);
    INV_RESET <= 1'b0;
    // Analog monitor: both items, in range and over range
    for (int i = 0; i < 4; i++) begin
      wr(A_CTRL, i[0] ? 32'h8 : 32'h0);
      e = i[0] ? 1000 : 6000;
      n = (i < 2) ? {$random(seed)} % e : e + 5;
      @(posedge CLK);
      OUT_FREQ <= 16'(n);
      OUT_CURRENT <= 16'(n);
      repeat (30) @(posedge CLK);
      @(negedge CLK);
      chk("analog", ANALOG_MONITOR_OUT, (n >= e) ? 1023 : n * 1024 / e);
    end
    // Serial: both ports at the fastest divisor
    wr(A_PANEL_DIV, 32'h0);
    wr(A_TERM_DIV, 32'h0);
    rd(A_TERM_DIV, r);
    chk("divisor clamp", r, 32'h28C);
    d1 = 8'($random(seed));
    wr(A_PANEL_DATA, 32'(d1));
    rd(A_SER_STAT, r);
    chk("panel busy", r, 32'h1);
    d2 = 8'($random(seed));
    wr(A_TERM_DATA, 32'(d2));
    e = 0;
    while ((pan_peer.rx_q.size() == 0 || trm_peer.rx_q.size() == 0) && e < 8000) begin
      @(posedge CLK);
      e++;
    end
    chk("panel frames", pan_peer.rx_q.size(), 1);
    chk("term frames", trm_peer.rx_q.size(), 1);
    if (pan_peer.rx_q.size() > 0) chk("panel tx", pan_peer.rx_q.pop_front(), d1);
    if (trm_peer.rx_q.size() > 0) chk("term tx", trm_peer.rx_q.pop_front(), d2);
    // Let the transmitters release the pairs before the peers talk
    repeat (700) @(posedge CLK);
    d1 = 8'($random(seed));
    d2 = 8'($random(seed));
    fork
      pan_peer.send(d1);
      trm_peer.send(d2);
    join
    rd(A_PANEL_DATA, r);
    chk("panel rx", r, 32'(d1));
    rd(A_TERM_DATA, r);
    chk("term rx", r, 32'(d2));
    rd(A_IRQ_STAT, r);
    chk("rx events", r & 32'h18, 32'h18);
    test_done;
  end
endmodule : tb
`default_nettype wire
